// file: sfh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfh_regs.svh"

// =====================================================================
module sfh_ctrl
    import sfh_pkg::*;
#(
    parameter int SOFT_RESET_CYCLES = `SFH_SOFT_RESET_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // serial pins
    input wire sfh_pins_s pins,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // configuration and state
    input wire sfh_cfg_s cfg,
    output sfh_stat_s stat,
    // array side
    output sfh_op_s nv_op,
    output sfh_op_s prog_byte,
    output logic nv_abort,
    input wire logic nv_done,
    output logic [23:0] rd_addr,
    input wire logic [7:0] rd_data
);
    typedef enum logic [4:0] {
        ST_OPCODE = 5'h01,
        ST_ADDR = 5'h02,
        ST_DIN = 5'h04,
        ST_DOUT = 5'h08,
        ST_SKIP = 5'h10
    } sfh_state_e;

    // =================================================================
    // helpers
    function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io, input logic quad);
        shift_in = quad ? {sh[19:0], io} : {sh[22:0], io[0]};
    endfunction

    function automatic logic [3:0] drive_bits(input logic [7:0] b, input logic quad);
        drive_bits = quad ? b[7:4] : {2'b00, b[7], 1'b0};
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] b, input logic quad);
        shift_out = quad ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
    endfunction

    // lock index: middle blocks 0..125, end sectors 126..157
    function automatic logic [7:0] lock_index(input logic [23:0] a);
        if (a[23:16] == 8'h00) begin
            lock_index = `SFH_MID_BLOCKS + {4'h0, a[15:12]};
        end else if (a[23:16] == `SFH_TOP_BLOCK) begin
            lock_index = `SFH_MID_BLOCKS + `SFH_SECTORS_PER_END + {4'h0, a[15:12]};
        end else begin
            lock_index = a[23:16] - 8'h01;
        end
    endfunction

    // =================================================================
    // pin synchronisers
    sfh_pins_s pins_s;
    // clock starts parked low so release of reset shows no false clock edge
    sfh_sync #(.W($bits(sfh_pins_s)), .INIT(8'hBE)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .d(pins),
        .q(pins_s)
    );

    sfh_state_e state_reg;
    logic sclk_d_reg, cs_d_reg, paused_reg, wel_reg, busy_reg, pd_reg, quad_reg, armed_reg, dtr_reg;
    logic pend_ready_reg;
    sfh_kind_e pend_kind_reg;
    logic [5:0] cnt_reg;
    logic [23:0] sh_reg, addr_reg;
    logic [7:0] out_sh_reg, wr_byte_reg;
    logic [8:0] rst_cnt_reg;
    logic [12:0] srst_cnt_reg;
    logic [11:0] pu_cnt_reg;
    logic [`SFH_LOCK_COUNT-1:0] lock_reg;

    logic sclk_rise, sclk_fall, selected, cs_rise, hold_fn, hw_rst_low, hw_rst_hit, init_ev, pu_inhibit;
    logic accept, rise_ev, fall_ev, take_in, opc_ev, addr_ev, byte_ev, out_ev, soft_go, status_ok;
    logic region_locked, exec_ok;
    logic [5:0] cnt_nx;
    logic [23:0] shifted;
    logic [7:0] opc, status_byte;

    // =================================================================
    // edge detection and pin roles
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= pins_s.sclk;
            cs_d_reg <= pins_s.cs_n;
        end
    end

    always_comb begin
        sclk_rise = pins_s.sclk & ~sclk_d_reg;
        sclk_fall = ~pins_s.sclk & sclk_d_reg;
        selected = ~pins_s.cs_n;
        cs_rise = pins_s.cs_n & ~cs_d_reg;
        hold_fn = ~cfg.quad_enable_bit & ~cfg.pin_role_reset;
        hw_rst_low = ~pins_s.reset_n | (~cfg.quad_enable_bit & cfg.pin_role_reset & ~pins_s.io[3]);
    end

    // =================================================================
    // pause: level check works for both orders of hold and clock edges
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            paused_reg <= 1'b0;
        end else if (!selected || !hold_fn) begin
            paused_reg <= 1'b0; // select rise drops the pause with the command state
        end else if (!pins_s.sclk) begin
            paused_reg <= ~pins_s.io[3];
        end
    end

    // =================================================================
    // hardware reset pulse measurement
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_reg <= 9'h000;
        end else if (!hw_rst_low) begin
            rst_cnt_reg <= 9'h000;
        end else if (rst_cnt_reg != 9'(`SFH_RESET_PULSE_CYCLES)) begin
            rst_cnt_reg <= rst_cnt_reg + 9'h001;
        end
    end

    // =================================================================
    // power-on style events and write inhibit after supply rise
    always_comb begin
        hw_rst_hit = hw_rst_low && rst_cnt_reg == 9'(`SFH_RESET_PULSE_CYCLES - 1);
        init_ev = hw_rst_hit | soft_go | ~pins_s.supply_ok;
        pu_inhibit = pu_cnt_reg != 12'(`SFH_POWERUP_WRITE_CYCLES);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pu_cnt_reg <= 12'h000;
        end else if (!pins_s.supply_ok) begin
            pu_cnt_reg <= 12'h000;
        end else if (pu_inhibit) begin
            pu_cnt_reg <= pu_cnt_reg + 12'h001;
        end
    end

    // soft reset busy window: no command is taken until it runs out
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            srst_cnt_reg <= 13'h0000;
        end else if (soft_go) begin
            srst_cnt_reg <= 13'(SOFT_RESET_CYCLES);
        end else if (srst_cnt_reg != 13'h0000) begin
            srst_cnt_reg <= srst_cnt_reg - 13'h0001;
        end
    end

    // =================================================================
    // bit-level decode
    always_comb begin
        accept = selected && !paused_reg && !hw_rst_low && pins_s.supply_ok && srst_cnt_reg == 13'h0000;
        rise_ev = sclk_rise & accept;
        fall_ev = sclk_fall & accept;
        // opcode only on rising edges; DTR address on both
        take_in = (state_reg == ST_OPCODE && rise_ev) || (state_reg == ST_DIN && rise_ev)
            || (state_reg == ST_ADDR && (rise_ev || (dtr_reg && fall_ev)));
        out_ev = state_reg == ST_DOUT && (fall_ev || (dtr_reg && rise_ev));
        shifted = shift_in(sh_reg, pins_s.io, quad_reg);
        cnt_nx = cnt_reg + (quad_reg ? 6'h04 : 6'h01);
        opc = shifted[7:0];
        opc_ev = state_reg == ST_OPCODE && take_in && cnt_nx == `SFH_OPCODE_BITS;
        addr_ev = state_reg == ST_ADDR && take_in && cnt_nx == `SFH_ADDR_BITS;
        byte_ev = state_reg == ST_DIN && take_in && cnt_nx == `SFH_BYTE_BITS;
        soft_go = opc_ev && armed_reg && opc == `SFH_OP_RESET_GO && !pd_reg;
        status_byte = `SFH_STAT_RESET_VAL;
        status_byte[`SFH_STAT_BUSY_POS] = busy_reg | (srst_cnt_reg != 13'h0000);
        status_byte[`SFH_STAT_WEL_POS] = wel_reg;
        status_byte[`SFH_STAT_QUAD_POS] = quad_reg;
        // protect pin only counts when it is not a data line
        status_ok = !cfg.status_lock_bit
            && !(cfg.status_protect_bit && !cfg.quad_enable_bit && !quad_reg && !pins_s.io[2]);
        if (pend_kind_reg == SFH_KIND_CHIP_ERASE) begin
            region_locked = cfg.protect_scheme_select ? |lock_reg : cfg.bp_region_hit;
        end else begin
            region_locked = cfg.protect_scheme_select ? lock_reg[lock_index(addr_reg)] : cfg.bp_region_hit;
        end
        case (pend_kind_reg)
            SFH_KIND_UNLOCK: exec_ok = 1'b1;
            SFH_KIND_STATUS_WRITE: exec_ok = wel_reg && status_ok;
            SFH_KIND_NONE: exec_ok = 1'b0;
            default: exec_ok = wel_reg && !region_locked;
        endcase
        exec_ok = exec_ok && pend_ready_reg && cs_rise && !paused_reg && !busy_reg && !hw_rst_low;
    end

    // =================================================================
    // command state machine; a pause simply freezes it in place
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_OPCODE;
            cnt_reg <= 6'h00;
            sh_reg <= 24'h000000;
            dtr_reg <= 1'b0;
        end else if (!selected || init_ev) begin
            state_reg <= ST_OPCODE;
            cnt_reg <= 6'h00;
            dtr_reg <= 1'b0;
        end else if (take_in) begin
            sh_reg <= shifted;
            cnt_reg <= (opc_ev || byte_ev) ? 6'h00 : cnt_nx;
            if (opc_ev) begin
                dtr_reg <= opc == `SFH_OP_READ_DTR;
                if (busy_reg) begin
                    state_reg <= opc == `SFH_OP_READ_STATUS ? ST_DOUT : ST_SKIP;
                end else if (pd_reg) begin
                    state_reg <= ST_SKIP;
                end else if (opc == `SFH_OP_READ_STATUS) begin
                    state_reg <= ST_DOUT;
                end else if (opc == `SFH_OP_READ || opc == `SFH_OP_READ_DTR || opc == `SFH_OP_UNLOCK) begin
                    state_reg <= ST_ADDR;
                end else if ((opc == `SFH_OP_PROGRAM || opc == `SFH_OP_SECTOR_ERASE
                        || opc == `SFH_OP_BLOCK_ERASE) && !pu_inhibit) begin
                    state_reg <= ST_ADDR;
                end else if (opc == `SFH_OP_WRITE_STATUS && !pu_inhibit) begin
                    state_reg <= ST_DIN;
                end else begin
                    state_reg <= ST_SKIP;
                end
            end else if (addr_ev) begin
                cnt_reg <= 6'h00;
                if (pend_kind_reg == SFH_KIND_PROGRAM) begin
                    state_reg <= ST_DIN;
                end else if (pend_kind_reg == SFH_KIND_NONE) begin
                    state_reg <= ST_DOUT;
                end else begin
                    state_reg <= ST_SKIP;
                end
            end else if (byte_ev && pend_kind_reg == SFH_KIND_STATUS_WRITE) begin
                state_reg <= ST_SKIP;
            end
        end else if (out_ev) begin
            cnt_reg <= cnt_nx == `SFH_BYTE_BITS ? 6'h00 : cnt_nx;
        end
    end

    // =================================================================
    // serial output: data changes on falling edges, both edges in DTR
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_sh_reg <= 8'h00;
            io_out <= 4'h0;
            addr_reg <= 24'h000000;
        end else if (addr_ev) begin
            addr_reg <= shifted;
        end else if (out_ev) begin
            if (cnt_reg == 6'h00) begin
                if (dtr_reg || pend_kind_reg == SFH_KIND_NONE && sh_reg[7:0] != `SFH_OP_READ_STATUS) begin
                    io_out <= drive_bits(rd_data, quad_reg);
                    out_sh_reg <= shift_out(rd_data, quad_reg);
                    addr_reg <= addr_reg + 24'h000001;
                end else begin
                    io_out <= drive_bits(status_byte, quad_reg);
                    out_sh_reg <= shift_out(status_byte, quad_reg);
                end
            end else begin
                io_out <= drive_bits(out_sh_reg, quad_reg);
                out_sh_reg <= shift_out(out_sh_reg, quad_reg);
            end
        end
    end

    // output released while deselected, paused or in reset
    always_comb begin
        io_oe = 4'h0;
        if (state_reg == ST_DOUT && selected && !paused_reg && !hw_rst_low) begin
            io_oe = quad_reg ? 4'hF : 4'h2;
        end
        rd_addr = addr_reg;
    end

    // =================================================================
    // pending write-type operation, carried until select rises
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pend_kind_reg <= SFH_KIND_NONE;
            pend_ready_reg <= 1'b0;
            wr_byte_reg <= 8'h00;
        end else if (!selected || init_ev) begin
            pend_kind_reg <= SFH_KIND_NONE;
            pend_ready_reg <= 1'b0;
        end else if (opc_ev && !busy_reg && !pd_reg && !pu_inhibit) begin
            pend_ready_reg <= opc == `SFH_OP_CHIP_ERASE;
            case (opc)
                `SFH_OP_PROGRAM: pend_kind_reg <= SFH_KIND_PROGRAM;
                `SFH_OP_SECTOR_ERASE: pend_kind_reg <= SFH_KIND_SECTOR_ERASE;
                `SFH_OP_BLOCK_ERASE: pend_kind_reg <= SFH_KIND_BLOCK_ERASE;
                `SFH_OP_CHIP_ERASE: pend_kind_reg <= SFH_KIND_CHIP_ERASE;
                `SFH_OP_WRITE_STATUS: pend_kind_reg <= SFH_KIND_STATUS_WRITE;
                `SFH_OP_UNLOCK: pend_kind_reg <= SFH_KIND_UNLOCK;
                default: pend_kind_reg <= SFH_KIND_NONE;
            endcase
        end else if (opc_ev && opc == `SFH_OP_UNLOCK && !pd_reg && !busy_reg) begin
            pend_kind_reg <= SFH_KIND_UNLOCK;
        end else if (addr_ev && pend_kind_reg != SFH_KIND_PROGRAM) begin
            pend_ready_reg <= pend_kind_reg != SFH_KIND_NONE;
        end else if (byte_ev) begin
            pend_ready_reg <= 1'b1;
            wr_byte_reg <= shifted[7:0];
        end
    end

    // =================================================================
    // operation requests towards the array
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nv_op <= '0;
            prog_byte <= '0;
            nv_abort <= 1'b0;
        end else begin
            nv_op.valid <= exec_ok && pend_kind_reg != SFH_KIND_UNLOCK;
            nv_op.kind <= pend_kind_reg;
            nv_op.addr <= addr_reg;
            nv_op.data <= wr_byte_reg;
            prog_byte.valid <= byte_ev && pend_kind_reg == SFH_KIND_PROGRAM;
            prog_byte.kind <= SFH_KIND_PROGRAM;
            prog_byte.addr <= addr_reg;
            prog_byte.data <= shifted[7:0];
            nv_abort <= busy_reg && (hw_rst_hit || !pins_s.supply_ok);
        end
    end

    // =================================================================
    // write latch, busy and mode flags
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wel_reg <= 1'b0;
            busy_reg <= 1'b0;
            pd_reg <= 1'b0;
            quad_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (init_ev) begin
            wel_reg <= 1'b0;
            pd_reg <= 1'b0;
            quad_reg <= 1'b0;
            armed_reg <= 1'b0;
            if (!soft_go) begin
                busy_reg <= 1'b0;
            end
        end else begin
            if (nv_done && busy_reg) begin
                busy_reg <= 1'b0;
                wel_reg <= 1'b0;
            end else if (exec_ok && pend_kind_reg != SFH_KIND_UNLOCK) begin
                busy_reg <= 1'b1;
            end
            if (opc_ev && !busy_reg) begin
                armed_reg <= opc == `SFH_OP_RESET_ARM && !pd_reg;
                if (pd_reg) begin
                    pd_reg <= opc != `SFH_OP_POWER_UP;
                end else begin
                    case (opc)
                        `SFH_OP_WR_ENABLE: wel_reg <= wel_reg | ~pu_inhibit;
                        `SFH_OP_WR_DISABLE: wel_reg <= 1'b0;
                        `SFH_OP_POWER_DOWN: pd_reg <= 1'b1;
                        `SFH_OP_QUAD_ENTER: quad_reg <= quad_reg | cfg.quad_enable_bit;
                        `SFH_OP_QUAD_EXIT: quad_reg <= 1'b0;
                        default: ;
                    endcase
                end
            end
        end
    end

    // =================================================================
    // individual locks; all set again by any power-on style event
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lock_reg <= `SFH_LOCK_RESET_VAL;
        end else if (init_ev) begin
            lock_reg <= `SFH_LOCK_RESET_VAL;
        end else if (exec_ok && pend_kind_reg == SFH_KIND_UNLOCK) begin
            lock_reg[lock_index(addr_reg)] <= 1'b0;
        end
    end

    // state view for the outside
    always_comb begin
        stat.write_enable_latch = wel_reg;
        stat.busy = busy_reg;
        stat.power_down = pd_reg;
        stat.quad_command_mode = quad_reg;
        stat.reset_busy = srst_cnt_reg != 13'h0000;
        stat.paused = paused_reg;
        stat.write_inhibit = pu_inhibit;
    end
endmodule // sfh_ctrl
`default_nettype wire

// file: sfh_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// port checker for the flash control block
module sfh_ctrl_checker
    import sfh_pkg::*;
#(
    parameter int SOFT_RESET_CYCLES = 7500
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // watched ports
    input wire sfh_pins_s pins,
    input wire sfh_cfg_s cfg,
    input wire logic [3:0] io_oe,
    input wire sfh_stat_s stat,
    input wire sfh_op_s nv_op,
    input wire logic nv_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [9:0] low_cnt;
    // raw reset pin low time; saturates well past sync plus the 250 cycle filter
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) low_cnt <= 10'h000;
        else if (pins.reset_n) low_cnt <= 10'h000;
        else if (!low_cnt[9]) low_cnt <= low_cnt + 10'h001;
    end
    AST_OP_LATCH: assert property (nv_op.valid |-> $past(stat.write_enable_latch))
        else $error("op without latch");
    AST_OP_INHIBIT: assert property (nv_op.valid |-> !$past(stat.write_inhibit))
        else $error("op during inhibit");
    AST_DONE_CLEAR: assert property (nv_done |=> !stat.write_enable_latch && !stat.busy)
        else $error("latch kept after done");
    AST_DOWN_QUIET: assert property (stat.power_down |-> !nv_op.valid)
        else $error("op in power-down");
    AST_PIN_QUIET: assert property (!pins.reset_n [*4] |-> !nv_op.valid)
        else $error("op under reset pin");
    AST_HW_RESET: assert property (low_cnt[9] |-> !stat.write_enable_latch && !stat.power_down && !stat.busy)
        else $error("reset pin ignored");
    AST_PAUSE_OFF: assert property (stat.paused [*2] |-> io_oe == 4'h0)
        else $error("driving while paused");
    AST_QUAD_PAUSE: assert property (cfg.quad_enable_bit [*3] |-> !stat.paused)
        else $error("pause with quad set");
    cover property (nv_op.valid);
    cover property (stat.paused);
    cover property (stat.reset_busy);
endmodule // sfh_ctrl_checker
bind sfh_ctrl sfh_ctrl_checker #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) i_sfh_ctrl_checker (.clock(clock),
    .nrst(nrst), .pins(pins), .cfg(cfg), .io_oe(io_oe), .stat(stat), .nv_op(nv_op), .nv_done(nv_done));
`default_nettype wire

// file: sfh_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench for the flash control block
module sfh_ctrl_tb
    import sfh_pkg::*;
;
    logic clock, nrst, reset_n, nv_done, cs_n, sclk, nv_abort, supply_ok;
    logic [3:0] io, io_out, io_oe;
    logic [23:0] rd_addr;
    sfh_cfg_s cfg;
    sfh_stat_s stat;
    sfh_op_s nv_op, prog_byte;
    sfh_pins_s pins;
    int n_errors = 0, check_count = 0, n_ops = 0, cyc = 0, n_prog = 0, n_abort = 0;
    assign pins = {cs_n, sclk, io, reset_n, supply_ok};
    sfh_ctrl #(.SOFT_RESET_CYCLES(200)) i_sfh_ctrl (.clock(clock), .nrst(nrst), .pins(pins), .io_out(io_out),
        .io_oe(io_oe), .cfg(cfg), .stat(stat), .nv_op(nv_op), .prog_byte(prog_byte), .nv_abort(nv_abort),
        .nv_done(nv_done), .rd_addr(rd_addr), .rd_data(rd_addr[7:0]));
    sfh_host i_sfh_host (.cs_n(cs_n), .sclk(sclk), .io(io), .rx_line(io_oe[1] ? io_out[1] : 1'b1));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // count issued operations; a hang ends the run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (nv_op.valid === 1'b1) n_ops <= n_ops + 1;
        if (prog_byte.valid === 1'b1) n_prog <= n_prog + 1;
        if (nv_abort === 1'b1) n_abort <= n_abort + 1;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d of %0d checks", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial begin
        nrst = 1'b0;
        reset_n = 1'b1;
        supply_ok = 1'b1;
        nv_done = 1'b0;
        cfg = '0;
        repeat (20) @(posedge clock);
        #1 nrst = 1'b1;
        chk("inhibit", 8'h01, stat.write_inhibit);
        i_sfh_host.cmd(8'h06);
        chk("latch", 8'h00, stat.write_enable_latch);
        repeat (2600) @(posedge clock);
        #1 i_sfh_host.send({8'h02, 24'h010000, 8'h5A}, 40);
        chk("ops", 8'h00, n_ops[7:0]);
        i_sfh_host.cmd(8'h06);
        chk("latch", 8'h01, stat.write_enable_latch);
        i_sfh_host.send({8'h05, 32'h0}, 16);
        chk("status", 8'h02, i_sfh_host.rx);
        i_sfh_host.send({8'h02, 24'h010000, 8'h5A}, 40);
        chk("ops", 8'h01, n_ops[7:0]);
        #8 nv_done = 1'b1;
        #4 nv_done = 1'b0;
        #8 chk("latch", 8'h00, stat.write_enable_latch);
        i_sfh_host.cmd(8'hB9);
        chk("down", 8'h01, stat.power_down);
        i_sfh_host.cmd(8'h06);
        chk("latch", 8'h00, stat.write_enable_latch);
        i_sfh_host.cmd(8'hAB);
        chk("down", 8'h00, stat.power_down);
        for (int q = 0; q < 2; q++) begin
            cfg.quad_enable_bit = q[0];
            fork
                i_sfh_host.pause(200);
                #100 chk("paused", {7'h00, ~q[0]}, stat.paused);
            join
            chk("paused", 8'h00, stat.paused);
        end
        i_sfh_host.cmd(8'h66);
        i_sfh_host.cmd(8'h04);
        i_sfh_host.cmd(8'h99);
        chk("rst busy", 8'h00, stat.reset_busy);
        i_sfh_host.cmd(8'h06);
        chk("latch", 8'h01, stat.write_enable_latch);
        cfg.protect_scheme_select = 1'b1;
        i_sfh_host.send({8'h02, 24'h010000, 8'h5A}, 40);
        chk("ops", 8'h01, n_ops[7:0]);
        i_sfh_host.send({8'h39, 24'h010000, 8'h00}, 32);
        i_sfh_host.send({8'h02, 24'h010000, 8'h5A}, 40);
        chk("ops", 8'h02, n_ops[7:0]);
        chk("bytes", 8'h04, n_prog[7:0]);
        reset_n = 1'b0;
        repeat (600) @(posedge clock);
        #1 chk("latch", 8'h00, stat.write_enable_latch);
        chk("aborts", 8'h01, n_abort[7:0]);
        reset_n = 1'b1;
        cfg = '0;
        #40 i_sfh_host.cmd(8'h66);
        i_sfh_host.cmd(8'h99);
        chk("rst busy", 8'h01, stat.reset_busy);
        #1000 chk("rst busy", 8'h00, stat.reset_busy);
        i_sfh_host.cmd(8'h06);
        chk("latch", 8'h01, stat.write_enable_latch);
        cfg.pin_role_reset = 1'b1;
        i_sfh_host.pause(1200);
        chk("latch", 8'h00, stat.write_enable_latch);
        supply_ok = 1'b0;
        repeat (8) @(posedge clock);
        #1 chk("inhibit", 8'h01, stat.write_inhibit);
        conclude();
    end
endmodule // sfh_ctrl_tb
`default_nettype wire

// file: sfh_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// host model: mode 0 serial master, 48 ns serial clock
module sfh_host (
    // serial lines
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io,
    // data line back from the block
    input wire logic rx_line
);
    logic [7:0] rx;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io = 4'hF;
    end
    // MSB first, data set while the clock is low
    task automatic send(input logic [39:0] v, input int n);
        cs_n = 1'b0;
        for (int i = 39; i > 39 - n; i--) begin
            #24 sclk = 1'b0;
            io[0] = v[i];
            #24 sclk = 1'b1;
            rx = {rx[6:0], rx_line};
        end
        #24 sclk = 1'b0;
        io[0] = ~io[0]; // released line must not look stable
        #24 cs_n = 1'b1;
        #96;
    endtask
    task automatic cmd(input logic [7:0] c);
        send({c, 32'h0}, 8);
    endtask
    // pause with the clock parked low; select held low all through
    task automatic pause(input int t);
        cs_n = 1'b0;
        #24 io[3] = 1'b0;
        #t io[3] = 1'b1;
        #24 cs_n = 1'b1;
        #96;
    endtask
endmodule // sfh_host
`default_nettype wire

// file: sfh_pkg.sv
`default_nettype none
package sfh_pkg;

    // =================================================================
    // pins as they arrive from the host side
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
        logic reset_n;
        logic supply_ok;
    } sfh_pins_s;

    // configuration held in the outside status register
    typedef struct packed {
        logic quad_enable_bit;
        logic pin_role_reset;
        logic protect_scheme_select;
        logic status_lock_bit;
        logic status_protect_bit;
        logic bp_region_hit;
    } sfh_cfg_s;

    typedef enum logic [2:0] {
        SFH_KIND_NONE = 3'h0,
        SFH_KIND_PROGRAM = 3'h1,
        SFH_KIND_SECTOR_ERASE = 3'h2,
        SFH_KIND_BLOCK_ERASE = 3'h3,
        SFH_KIND_CHIP_ERASE = 3'h4,
        SFH_KIND_STATUS_WRITE = 3'h5,
        SFH_KIND_UNLOCK = 3'h6
    } sfh_kind_e;

    // request towards the array and status storage
    typedef struct packed {
        logic valid;
        sfh_kind_e kind;
        logic [23:0] addr;
        logic [7:0] data;
    } sfh_op_s;

    typedef struct packed {
        logic write_enable_latch;
        logic busy;
        logic power_down;
        logic quad_command_mode;
        logic reset_busy;
        logic paused;
        logic write_inhibit;
    } sfh_stat_s;

endpackage
`default_nettype wire

// file: sfh_regs.svh
`ifndef SFH_REGS_SVH
`define SFH_REGS_SVH

// =====================================================================
// instruction codes
`define SFH_OP_WR_ENABLE 8'h06
`define SFH_OP_WR_DISABLE 8'h04
`define SFH_OP_RESET_ARM 8'h66
`define SFH_OP_RESET_GO 8'h99
`define SFH_OP_POWER_DOWN 8'hB9
`define SFH_OP_POWER_UP 8'hAB
`define SFH_OP_QUAD_ENTER 8'h38
`define SFH_OP_QUAD_EXIT 8'hFF
`define SFH_OP_READ_STATUS 8'h05
`define SFH_OP_READ 8'h03
`define SFH_OP_READ_DTR 8'h0D
`define SFH_OP_PROGRAM 8'h02
`define SFH_OP_SECTOR_ERASE 8'h20
`define SFH_OP_BLOCK_ERASE 8'hD8
`define SFH_OP_CHIP_ERASE 8'hC7
`define SFH_OP_WRITE_STATUS 8'h01
`define SFH_OP_UNLOCK 8'h39

// =====================================================================
// frame geometry
`define SFH_OPCODE_BITS 6'h08
`define SFH_ADDR_BITS 6'h18
`define SFH_BYTE_BITS 6'h08

// =====================================================================
// status byte returned by the status read
`define SFH_STAT_BUSY_POS 0
`define SFH_STAT_WEL_POS 1
`define SFH_STAT_QUAD_POS 2
`define SFH_STAT_RESET_VAL 8'h00

// =====================================================================
// lock bit geometry: middle blocks first, then bottom sectors, then top sectors
`define SFH_LOCK_COUNT 158
`define SFH_MID_BLOCKS 8'h7E
`define SFH_TOP_BLOCK 8'h7F
`define SFH_SECTORS_PER_END 8'h10
`define SFH_LOCK_RESET_VAL {`SFH_LOCK_COUNT{1'b1}}

// =====================================================================
// timing
`define SFH_CLK_PERIOD_PS 4000
`define SFH_RESET_PULSE_MIN_NS 1000
`define SFH_RESET_PULSE_CYCLES ((`SFH_RESET_PULSE_MIN_NS * 1000 + `SFH_CLK_PERIOD_PS - 1) / `SFH_CLK_PERIOD_PS)
`define SFH_SOFT_RESET_NS 30000
`define SFH_SOFT_RESET_CYCLES (`SFH_SOFT_RESET_NS * 1000 / `SFH_CLK_PERIOD_PS)
`define SFH_POWERUP_WRITE_DELAY_US 10
`define SFH_POWERUP_WRITE_CYCLES (`SFH_POWERUP_WRITE_DELAY_US * 1000000 / `SFH_CLK_PERIOD_PS)

`endif

// file: sfh_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// two-stage synchroniser for pins arriving from outside the clock domain
module sfh_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= INIT;
            q <= INIT;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // sfh_sync
`default_nettype wire
